// file: verilog/compare_pkg.sv
// Package with register map, field layout, reset values and bus types of the output compare unit.
package compare_pkg;

	// Register byte addresses on the Wishbone slave.
	localparam logic [7:0] ADDR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_FORCE     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h08;
	localparam logic [7:0] ADDR_FLAGS     = 8'h0C;
	localparam logic [7:0] ADDR_CMPA_LOW  = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HIGH = 8'h14;
	localparam logic [7:0] ADDR_CMPB_LOW  = 8'h18;
	localparam logic [7:0] ADDR_CMPB_HIGH = 8'h1C;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;

	// Control register fields.
	localparam int MODE_LSB   = 0;
	localparam int ACTA_LSB   = 4;
	localparam int ACTB_LSB   = 6;
	localparam int CHANNELS   = 2;

	// Reset values.
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;
	localparam logic [7:0]  TEMP_RESET    = 8'h00;

	// Compare output actions.
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// Waveform modes with special meaning.
	localparam logic [3:0] MODE_NORMAL    = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
	localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
	localparam logic [3:0] MODE_RESERVED  = 4'hD;
	localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
	localparam logic [3:0] MODE_PFC_CMPA  = 4'h9;
	localparam logic [3:0] MODE_PC_CMPA   = 4'hB;
	localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

	typedef enum {
		WAVE_NON_PWM,
		WAVE_FAST,
		WAVE_PHASE,
		WAVE_PHASE_FREQ
	} waveClass_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wbReq_t;

	typedef struct packed {
		logic [15:0] timerCount;
		logic        timerTick;
		logic        countCeiling;
		logic        countFloor;
		logic        countingDown;
		logic        countWrite;
	} counterView_t;

endpackage

// file: verilog/timer_output_compare_unit.sv
// Two-channel output compare unit with Wishbone register access and port pin override.
//
// What this block does
// - Each channel compares the full 16-bit count with its compare value continuously.
// - A match sets the channel's match flag on the timer tick, not earlier.
// - Enabled flags raise an interrupt request; servicing the interrupt clears the flag.
// - Software clears a match flag by writing one; writing zero leaves it.
// - Output level follows match, waveform mode and compare output action.
// - Ceiling and floor indications handle the extreme-value cases in PWM modes.
// - Channel A's compare value can serve as the counter ceiling.
// - Compare value is double buffered in the twelve PWM modes only.
// - Buffered value moves to the active register only at ceiling or floor.
// - CPU reaches the buffer when buffering, else the active register.
// - Only CPU writes and the buffer transfer change the compare value; high byte reads bypass the latch.
// - High byte write loads the latch; low byte write loads all sixteen bits.
// - Force strobe in non-PWM modes acts like a match without flag or counter effect.
// - A count write suppresses compare matches in the following timer tick.
// - Writing count equal to a variable ceiling loses that ceiling match.
// - Output level survives mode changes and resets to zero.
// - A new output action applies at the first match after the write.
// - Nonzero output action puts the level on the pin; direction stays external.
// - Output action zero leaves the output level unchanged on matches.
// - Output action has no influence on input capture.
// - Modes 4 and 12 clear the counter on match, ceiling from A or capture.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module timer_output_compare_unit
(
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire compare_pkg::wbReq_t           wbReq,
	output logic                               wbAck,
	output logic [31:0]                        wbDatOut,
	input  wire compare_pkg::counterView_t     counter,
	input  wire logic [1:0]                    irqServiced,
	output logic [1:0]                         irqRequest,
	output logic [15:0]                        ceilingValue,
	output logic                               ceilingFromA,
	output logic                               clearOnMatchMode,
	input  wire logic [1:0]                    portData,
	input  wire logic [1:0]                    outputPinDirection,
	output logic [1:0]                         pinOut,
	output logic [1:0]                         pinOutEn
);

	logic [7:0]                control_q;
	logic [1:0]                irqEnable_q;
	logic [1:0]                matchFlag_q;
	logic [1:0]                outputLevel_q;
	logic [7:0]                tempHigh_q;
	logic                      matchBlock_q;
	logic                      ack_q;
	logic [31:0]               rdData_q;
	logic [15:0]               activeCmp_q [2];
	logic [15:0]               bufferCmp_q [2];

	logic [3:0]                waveformModeSel;
	logic [1:0]                compareOutputAction [2];
	compare_pkg::waveClass_t   waveClass;
	logic                      buffered;
	logic                      updatePoint;
	logic                      busReq;
	logic                      busWrite;
	logic [7:0]                wrByte;
	logic [1:0]                matchRaw;
	logic [1:0]                matchHit;
	logic [1:0]                forceStrobe;
	logic [1:0]                flagClearWrite;
	logic [1:0]                lowWrite;
	logic                      highWrite;
	logic [7:0]                rdNext;

	assign waveformModeSel        = control_q[compare_pkg::MODE_LSB +: 4];
	assign compareOutputAction[0] = control_q[compare_pkg::ACTA_LSB +: 2];
	assign compareOutputAction[1] = control_q[compare_pkg::ACTB_LSB +: 2];

	// Mode classification; mode 13 is reserved and handled like the non-PWM modes.
	always_comb
	begin
		case (waveformModeSel)
			compare_pkg::MODE_NORMAL,
			compare_pkg::MODE_CTC_CMPA,
			compare_pkg::MODE_CTC_CAPT,
			compare_pkg::MODE_RESERVED:  waveClass = compare_pkg::WAVE_NON_PWM;
			4'h5, 4'h6, 4'h7, 4'hE,
			compare_pkg::MODE_FAST_CMPA: waveClass = compare_pkg::WAVE_FAST;
			compare_pkg::MODE_PFC_CAPT,
			compare_pkg::MODE_PFC_CMPA:  waveClass = compare_pkg::WAVE_PHASE_FREQ;
			default:                     waveClass = compare_pkg::WAVE_PHASE;
		endcase
	end

	assign buffered = (waveClass != compare_pkg::WAVE_NON_PWM);

	// Fast and phase correct modes update at the ceiling, phase and frequency correct at the floor.
	assign updatePoint = counter.timerTick &&
		((waveClass == compare_pkg::WAVE_PHASE_FREQ) ? counter.countFloor : counter.countCeiling);

	assign ceilingValue     = activeCmp_q[0];
	assign ceilingFromA     = (waveformModeSel == compare_pkg::MODE_CTC_CMPA)  ||
	                          (waveformModeSel == compare_pkg::MODE_FAST_CMPA) ||
	                          (waveformModeSel == compare_pkg::MODE_PFC_CMPA)  ||
	                          (waveformModeSel == compare_pkg::MODE_PC_CMPA);
	assign clearOnMatchMode = (waveformModeSel == compare_pkg::MODE_CTC_CMPA) ||
	                          (waveformModeSel == compare_pkg::MODE_CTC_CAPT);

	// Bus handshake: the request is answered one cycle after it appears, writes land on the ack edge.
	assign busReq   = wbReq.cyc && wbReq.stb;
	assign busWrite = busReq && ack_q && wbReq.we && wbReq.sel[0];
	assign wrByte   = wbReq.dat[7:0];
	assign wbAck    = ack_q;
	assign wbDatOut = rdData_q;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			ack_q <= 1'b0;
		else
			ack_q <= busReq && !ack_q;
	end

	// Write decode into per-register strobes.
	always_comb
	begin
		forceStrobe    = 2'b00;
		flagClearWrite = 2'b00;
		lowWrite       = 2'b00;
		highWrite      = 1'b0;
		if (busWrite)
		begin
			if (wbReq.adr == compare_pkg::ADDR_FORCE)
				forceStrobe = wrByte[1:0];
			else if (wbReq.adr == compare_pkg::ADDR_FLAGS)
				flagClearWrite = wrByte[1:0];
			else if (wbReq.adr == compare_pkg::ADDR_CMPA_LOW)
				lowWrite = 2'b01;
			else if (wbReq.adr == compare_pkg::ADDR_CMPB_LOW)
				lowWrite = 2'b10;
			else if (wbReq.adr == compare_pkg::ADDR_CMPA_HIGH || wbReq.adr == compare_pkg::ADDR_CMPB_HIGH)
				highWrite = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			control_q <= compare_pkg::CONTROL_RESET;
		else if (busWrite && wbReq.adr == compare_pkg::ADDR_CONTROL)
			control_q <= wrByte;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			irqEnable_q <= 2'b00;
		else if (busWrite && wbReq.adr == compare_pkg::ADDR_IRQ_EN)
			irqEnable_q <= wrByte[1:0];
	end

	// One latch serves both channels, so high then low must not be interleaved between channels.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			tempHigh_q <= compare_pkg::TEMP_RESET;
		else if (highWrite)
			tempHigh_q <= wrByte;
	end

	// A count write blocks matches until the next timer tick has passed, even with the tick stopped.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			matchBlock_q <= 1'b0;
		else if (counter.countWrite)
			matchBlock_q <= 1'b1;
		else if (counter.timerTick)
			matchBlock_q <= 1'b0;
	end

	// Read path; high byte reads return the register itself, never the latch.
	always_comb
	begin
		rdNext = 8'h00;
		if (wbReq.adr == compare_pkg::ADDR_CONTROL)
			rdNext = control_q;
		else if (wbReq.adr == compare_pkg::ADDR_IRQ_EN)
			rdNext = {6'h00, irqEnable_q};
		else if (wbReq.adr == compare_pkg::ADDR_FLAGS)
			rdNext = {6'h00, matchFlag_q};
		else if (wbReq.adr == compare_pkg::ADDR_CMPA_LOW)
			rdNext = buffered ? bufferCmp_q[0][7:0] : activeCmp_q[0][7:0];
		else if (wbReq.adr == compare_pkg::ADDR_CMPA_HIGH)
			rdNext = buffered ? bufferCmp_q[0][15:8] : activeCmp_q[0][15:8];
		else if (wbReq.adr == compare_pkg::ADDR_CMPB_LOW)
			rdNext = buffered ? bufferCmp_q[1][7:0] : activeCmp_q[1][7:0];
		else if (wbReq.adr == compare_pkg::ADDR_CMPB_HIGH)
			rdNext = buffered ? bufferCmp_q[1][15:8] : activeCmp_q[1][15:8];
		else if (wbReq.adr == compare_pkg::ADDR_STATUS)
			rdNext = {6'h00, outputLevel_q};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			rdData_q <= 32'h0000_0000;
		else if (busReq && !ack_q)
			rdData_q <= {24'h00_0000, rdNext};
	end

	genvar ch;
	generate
		for (ch = 0; ch < compare_pkg::CHANNELS; ch++)
		begin : gen_channel
			logic levelNext;

			assign matchRaw[ch] = (counter.timerCount == activeCmp_q[ch]);
			// A blocked tick also drops a ceiling match, so the counter runs on to its maximum.
			assign matchHit[ch] = counter.timerTick && matchRaw[ch] && !matchBlock_q;

			// Compare registers change only through the CPU or the buffer transfer.
			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					bufferCmp_q[ch] <= compare_pkg::COMPARE_RESET;
				else if (lowWrite[ch] && buffered)
					bufferCmp_q[ch] <= {tempHigh_q, wrByte};
			end

			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					activeCmp_q[ch] <= compare_pkg::COMPARE_RESET;
				else if (lowWrite[ch] && !buffered)
					activeCmp_q[ch] <= {tempHigh_q, wrByte};
				else if (buffered && updatePoint)
					activeCmp_q[ch] <= bufferCmp_q[ch];
			end

			// A new match wins over a clear arriving in the same cycle.
			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					matchFlag_q[ch] <= 1'b0;
				else if (matchHit[ch])
					matchFlag_q[ch] <= 1'b1;
				else if (flagClearWrite[ch] || (irqServiced[ch] && irqEnable_q[ch]))
					matchFlag_q[ch] <= 1'b0;
			end

			assign irqRequest[ch] = matchFlag_q[ch] && irqEnable_q[ch];

			// Waveform generator; action zero never touches the level.
			always_comb
			begin
				levelNext = outputLevel_q[ch];
				case (waveClass)
					compare_pkg::WAVE_NON_PWM:
					begin
						if (matchHit[ch] || forceStrobe[ch])
						begin
							case (compareOutputAction[ch])
								compare_pkg::ACT_TOGGLE: levelNext = !outputLevel_q[ch];
								compare_pkg::ACT_CLEAR:  levelNext = 1'b0;
								compare_pkg::ACT_SET:    levelNext = 1'b1;
								default:                 levelNext = outputLevel_q[ch];
							endcase
						end
					end
					compare_pkg::WAVE_FAST:
					begin
						// Floor sets up the period; a match at the floor still wins for a narrow pulse.
						if (counter.timerTick && counter.countFloor && compareOutputAction[ch][1])
							levelNext = !compareOutputAction[ch][0];
						if (matchHit[ch])
						begin
							if (compareOutputAction[ch][1])
								levelNext = compareOutputAction[ch][0];
							else if (compareOutputAction[ch] == compare_pkg::ACT_TOGGLE && ch == 0 &&
								waveformModeSel == compare_pkg::MODE_FAST_CMPA)
								levelNext = !outputLevel_q[ch];
						end
					end
					default:
					begin
						// Dual slope: the level set on the up slope is the inverse of the down slope.
						if (matchHit[ch])
						begin
							if (compareOutputAction[ch][1])
								levelNext = compareOutputAction[ch][0] ^ counter.countingDown;
							else if (compareOutputAction[ch] == compare_pkg::ACT_TOGGLE && ch == 0 &&
								ceilingFromA)
								levelNext = !outputLevel_q[ch];
						end
						// A compare value above the ceiling or at the floor still gives a full-width extreme.
						else if (counter.timerTick && compareOutputAction[ch][1] &&
							((counter.countCeiling && activeCmp_q[ch] > counter.timerCount) ||
							 (counter.countFloor && activeCmp_q[ch] == counter.timerCount)))
							levelNext = !compareOutputAction[ch][0] ^ counter.countFloor;
					end
				endcase
			end

			// The level keeps its value across mode changes; reset clears it to zero.
			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					outputLevel_q[ch] <= 1'b0;
				else
					outputLevel_q[ch] <= levelNext;
			end

			// Any nonzero action takes the pin from the port; direction stays with the port bit.
			assign pinOut[ch]   = (compareOutputAction[ch] != compare_pkg::ACT_NONE) ?
				outputLevel_q[ch] : portData[ch];
			assign pinOutEn[ch] = outputPinDirection[ch];
		end
	endgenerate

endmodule

// file: tb/timer_output_compare_unit_assertions.sv
// Port-level checker for the output compare unit, bound to its top module.
`timescale 1ns/1ps

module timer_output_compare_unit_assertions
(
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire compare_pkg::wbReq_t       wbReq,
	input  wire logic                      wbAck,
	input  wire logic [31:0]               wbDatOut,
	input  wire compare_pkg::counterView_t counter,
	input  wire logic [1:0]                irqServiced,
	input  wire logic [1:0]                irqRequest,
	input  wire logic [15:0]               ceilingValue,
	input  wire logic                      ceilingFromA,
	input  wire logic                      clearOnMatchMode,
	input  wire logic [1:0]                portData,
	input  wire logic [1:0]                outputPinDirection,
	input  wire logic [1:0]                pinOut,
	input  wire logic [1:0]                pinOutEn
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence busRequest;
		wbReq.cyc && wbReq.stb && !wbAck;
	endsequence
	sequence countWriteThenTick;
		counter.countWrite ##1 counter.timerTick;
	endsequence

	a_ack_answer: assert property (busRequest |=> wbAck)
		else $error("ack did not follow a request by one cycle");
	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack stood longer than one cycle");
	// A register write may enable an already set flag, so only tick-born rises are traced to a match.
	a_flag_a_match: assert property (($rose(irqRequest[0]) && !$past(wbAck && wbReq.we))
		|-> $past(counter.timerTick && counter.timerCount == ceilingValue)) else $error("channel A flag without match");
	a_flag_b_tick: assert property (($rose(irqRequest[1]) && !$past(wbAck && wbReq.we)) |-> $past(counter.timerTick))
		else $error("channel B flag rose without a timer tick");
	a_write_blocks: assert property (countWriteThenTick |=> !$rose(irqRequest[0]) && !$rose(irqRequest[1]))
		else $error("match not blocked after a count write");
	a_service_clears: assert property ((irqServiced[0] && irqRequest[0] && !counter.timerTick) |=> !irqRequest[0])
		else $error("serviced interrupt left its flag set");
	a_ceiling_hold: assert property ((!$stable(ceilingValue) && $past(resetn))
		|-> $past(wbAck && wbReq.we) || $past(counter.timerTick)) else $error("compare value changed without cause");
	a_pin_direction: assert property (pinOutEn == outputPinDirection)
		else $error("pin enable differs from port direction");
endmodule

bind timer_output_compare_unit timer_output_compare_unit_assertions u_timer_output_compare_unit_assertions
(
	.sys_clk(sys_clk), .resetn(resetn), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .counter(counter),
	.irqServiced(irqServiced), .irqRequest(irqRequest), .ceilingValue(ceilingValue), .ceilingFromA(ceilingFromA),
	.clearOnMatchMode(clearOnMatchMode), .portData(portData), .outputPinDirection(outputPinDirection),
	.pinOut(pinOut), .pinOutEn(pinOutEn)
);

// file: tb/cpu_port_model.sv
// Behavioural model of the processor bus master and the port pin logic facing the compare unit.
`timescale 1ns/1ps

module cpu_port_model
(
	input  wire logic            sys_clk,
	input  wire logic            wbAck,
	input  wire logic [31:0]     wbDatOut,
	input  wire logic [1:0]      pinOut,
	input  wire logic [1:0]      pinOutEn,
	output compare_pkg::wbReq_t  wbReq,
	output logic [1:0]           portData,
	output logic [1:0]           outputPinDirection,
	output logic [1:0]           pinLevel
);
	initial
	begin
		wbReq = '0;
		portData = 2'h0;
		outputPinDirection = 2'h0;
	end

	// An undriven pin floats up to the port pull-up, so a missing enable never reads as a valid low.
	assign pinLevel = (pinOut & pinOutEn) | ~pinOutEn;

	task automatic busCycle(input logic [7:0] adr, input logic we, input logic [7:0] dat, output logic [7:0] rd);
		wbReq <= '{1'h1, 1'h1, we, adr, 4'hF, {24'h000000, dat}};
		do
			@(posedge sys_clk);
		while (wbAck !== 1'h1);
		rd = wbDatOut[7:0];
		wbReq <= '0;
		@(posedge sys_clk);
	endtask

	task automatic busWrite(input logic [7:0] adr, input logic [7:0] dat);
		logic [7:0] ignored;
		busCycle(adr, 1'h1, dat, ignored);
	endtask

	task automatic busRead(input logic [7:0] adr, output logic [7:0] rd);
		busCycle(adr, 1'h0, 8'h00, rd);
	endtask

	task automatic compareWrite(input logic [7:0] lowAdr, input logic [7:0] highAdr, input logic [15:0] value);
		busWrite(highAdr, value[15:8]);
		busWrite(lowAdr, value[7:0]);
	endtask

	// Callers set the output level and the direction together, on one clock edge.
	task automatic setPort(input logic [1:0] data, input logic [1:0] dir);
		portData <= data;
		outputPinDirection <= dir;
		@(posedge sys_clk);
	endtask
endmodule

// file: tb/tb_timer_output_compare_unit.sv
// Self-checking bench for the output compare unit.
`timescale 1ns/1ps

module tb_timer_output_compare_unit;
	typedef struct packed
	{
		logic [7:0] adr;
		logic [7:0] wdat;
		logic [7:0] rexp;
	} row_t;

	logic                      sys_clk = 1'h0;
	logic                      resetn = 1'h0;
	compare_pkg::wbReq_t       wbReq;
	logic                      wbAck;
	logic [31:0]               wbDatOut;
	compare_pkg::counterView_t counter = '0;
	logic [1:0]                irqServiced = 2'h0;
	logic [1:0]                irqRequest;
	logic [15:0]               ceilingValue;
	logic                      ceilingFromA;
	logic                      clearOnMatchMode;
	logic [1:0]                portData;
	logic [1:0]                outputPinDirection;
	logic [1:0]                pinOut;
	logic [1:0]                pinOutEn;
	logic [1:0]                pinLevel;
	logic [7:0]                level;
	int                        failures = 0;
	int                        checked = 0;
	int                        cycles = 0;
	row_t                      rows [5] = '{'{8'h08, 8'hFF, 8'h03}, '{8'h04, 8'h01, 8'h00}, '{8'h24, 8'h5A, 8'h00},
		'{8'h00, 8'hE6, 8'hE6}, '{8'h00, 8'h10, 8'h10}};

	timer_output_compare_unit u_timer_output_compare_unit (.sys_clk(sys_clk), .resetn(resetn), .wbReq(wbReq),
		.wbAck(wbAck), .wbDatOut(wbDatOut), .counter(counter), .irqServiced(irqServiced), .irqRequest(irqRequest),
		.ceilingValue(ceilingValue), .ceilingFromA(ceilingFromA), .clearOnMatchMode(clearOnMatchMode),
		.portData(portData), .outputPinDirection(outputPinDirection), .pinOut(pinOut), .pinOutEn(pinOutEn));
	cpu_port_model u_cpu_port_model (.sys_clk(sys_clk), .wbAck(wbAck), .wbDatOut(wbDatOut), .pinOut(pinOut),
		.pinOutEn(pinOutEn), .wbReq(wbReq), .portData(portData), .outputPinDirection(outputPinDirection),
		.pinLevel(pinLevel));

	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rdCheck(input logic [7:0] adr, input logic [7:0] exp);
		logic [7:0] data;
		u_cpu_port_model.busRead(adr, data);
		check(16'(data), 16'(exp));
	endtask

	// The bench plays the counter; the floor flag is kept honest so buffer transfers see real levels.
	task automatic tick(input logic [15:0] count, input logic ceil);
		counter.timerCount <= count;
		counter.countFloor <= (count == 16'h0000);
		counter.countCeiling <= ceil;
		counter.timerTick <= 1'h1;
		@(posedge sys_clk);
		counter.timerTick <= 1'h0;
		counter.countCeiling <= 1'h0;
		@(posedge sys_clk);
	endtask

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			conclude();
		end
	end

	initial
	begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'h1;
		@(posedge sys_clk);
		check(16'(irqRequest), 16'h0000);
		check(16'(pinLevel), 16'h0003);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h00);
		foreach (rows[i])
		begin
			u_cpu_port_model.busWrite(rows[i].adr, rows[i].wdat);
			rdCheck(rows[i].adr, rows[i].rexp);
		end
		u_cpu_port_model.compareWrite(compare_pkg::ADDR_CMPA_LOW, compare_pkg::ADDR_CMPA_HIGH, 16'h1234);
		check(ceilingValue, 16'h1234);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_CMPB_HIGH, 8'h77);
		rdCheck(compare_pkg::ADDR_CMPA_HIGH, 8'h12);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_CMPB_LOW, 8'h00);
		rdCheck(compare_pkg::ADDR_CMPB_HIGH, 8'h77);
		tick(16'h1233, 1'h0);
		check(16'(irqRequest), 16'h0000);
		tick(16'h1234, 1'h0);
		check(16'(irqRequest), 16'h0001);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		u_cpu_port_model.setPort(2'h0, 2'h3);
		check(16'(pinLevel), 16'h0001);
		irqServiced <= 2'h1;
		@(posedge sys_clk);
		irqServiced <= 2'h0;
		@(posedge sys_clk);
		check(16'(irqRequest), 16'h0000);
		tick(16'h7700, 1'h0);
		check(16'(irqRequest), 16'h0002);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_FLAGS, 8'h00);
		rdCheck(compare_pkg::ADDR_FLAGS, 8'h02);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_FLAGS, 8'h02);
		rdCheck(compare_pkg::ADDR_FLAGS, 8'h00);
		counter.countWrite <= 1'h1;
		@(posedge sys_clk);
		counter.countWrite <= 1'h0;
		repeat (3) @(posedge sys_clk);
		tick(16'h1234, 1'h0);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		counter.countWrite <= 1'h1;
		@(posedge sys_clk);
		counter.countWrite <= 1'h0;
		tick(16'h1234, 1'h0);
		check(16'(irqRequest), 16'h0000);
		tick(16'h1234, 1'h0);
		check(16'(irqRequest), 16'h0001);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_FLAGS, 8'h03);
		level = 8'h00;
		for (int a = 3; a >= 1; a--)
		begin
			u_cpu_port_model.busWrite(compare_pkg::ADDR_CONTROL, 8'(a * 16));
			level = (a == 3) ? 8'h01 : (a == 2) ? 8'h00 : (level ^ 8'h01);
			u_cpu_port_model.busWrite(compare_pkg::ADDR_FORCE, 8'h01);
			rdCheck(compare_pkg::ADDR_STATUS, level);
			rdCheck(compare_pkg::ADDR_FLAGS, 8'h00);
		end
		u_cpu_port_model.busWrite(compare_pkg::ADDR_CONTROL, 8'h2F);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_FORCE, 8'h01);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		u_cpu_port_model.setPort(2'h2, 2'h3);
		check(16'(pinOut), 16'h0003);
		u_cpu_port_model.compareWrite(compare_pkg::ADDR_CMPA_LOW, compare_pkg::ADDR_CMPA_HIGH, 16'h0100);
		check(ceilingValue, 16'h1234);
		tick(16'h0005, 1'h0);
		check(ceilingValue, 16'h1234);
		tick(16'h1234, 1'h1);
		check(ceilingValue, 16'h0100);
		// Dual slope with clear action: the up-slope match clears, the down-slope match sets.
		u_cpu_port_model.busWrite(compare_pkg::ADDR_CONTROL, 8'h29);
		counter.countingDown <= 1'h1;
		tick(16'h0100, 1'h0);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		counter.countingDown <= 1'h0;
		tick(16'h0100, 1'h0);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h00);
		u_cpu_port_model.compareWrite(compare_pkg::ADDR_CMPA_LOW, compare_pkg::ADDR_CMPA_HIGH, 16'h0200);
		check(ceilingValue, 16'h0100);
		tick(16'h0000, 1'h0);
		check(ceilingValue, 16'h0200);
		for (int m = 0; m < 16; m++)
		begin
			u_cpu_port_model.busWrite(compare_pkg::ADDR_CONTROL, 8'(m));
			check(16'(clearOnMatchMode), 16'(m == 4 || m == 12));
			check(16'(ceilingFromA), 16'(m == 4 || m == 9 || m == 11 || m == 15));
		end
		// Drive the level high first so that the reset check below can tell a cleared level apart.
		u_cpu_port_model.busWrite(compare_pkg::ADDR_CONTROL, 8'h30);
		u_cpu_port_model.busWrite(compare_pkg::ADDR_FORCE, 8'h01);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h01);
		resetn <= 1'h0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'h1;
		@(posedge sys_clk);
		check(16'(irqRequest), 16'h0000);
		rdCheck(compare_pkg::ADDR_STATUS, 8'h00);
		conclude();
	end
endmodule
